/* File: src/prmc_ctrl.sv */
// Purpose: idle and power-down mode sequencing
// Assumes: reset_input_pin drives rst_in through external sync
// Notes: requests stay pending while the bus is busy
`timescale 1ns/10ps
`include "prmc_consts.svh"
module prmc_ctrl #(
  parameter int NUM_IRQ = `PRMC_NUM_EXT_IRQ
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // cpu side
  input wire prmc_pkg::prmc_cpu_req_t cpu_in,
  input wire logic [15:0] system_config_register_in,
  input wire logic main_regulator_off_bit_in,
  input wire logic lp_osc_disable_in,
  // pins and wake sources
  input wire logic nmi_n_in,
  input wire logic [NUM_IRQ-1:0] fast_external_irq_pin_in,
  input wire logic [NUM_IRQ-1:0] irq_enable_in,
  input wire logic [NUM_IRQ-1:0] irq_active_high_in,
  input wire logic lp_osc_running_in,
  input wire prmc_pkg::prmc_wake_t wake_in,
  // status and control
  output logic cpu_halt_out,
  output logic periph_clk_en_out,
  output logic wdt_hold_out,
  output logic main_osc_en_out,
  output logic rtc_ref_lp_out,
  output logic entry_refused_out,
  output logic wake_irq_out,
  output logic [3:0] mode_out
);
  prmc_pkg::prmc_state_t state, next_state;
  logic [NUM_IRQ-1:0] s1, s2, s3, next_s1, next_s2, next_s3, irq_lvl, next_irq_lvl;
  logic [2:0] cnt [NUM_IRQ];
  logic [2:0] next_cnt [NUM_IRQ];
  logic idle_pend, next_idle_pend, pd_pend, next_pd_pend, rdy_ok;
  logic nmi1, nmi2, nmi3, next_nmi1, next_nmi2, next_nmi3, nmi_lvl, next_nmi_lvl;
  logic lp1, lp2, lp3, next_lp1, next_lp2, next_lp3, lp_ref, next_lp_ref;
  logic next_halt, next_pclk, next_wdt, next_mosc, next_ref, next_refused, next_wake;
  logic [NUM_IRQ-1:0] irq_act, irq_wake;

  // asserted level of a fast irq line after polarity
  function automatic logic [NUM_IRQ-1:0] active_lvl(input logic [NUM_IRQ-1:0] v,
                                                    input logic [NUM_IRQ-1:0] pol);
    active_lvl = ~(v ^ pol);
  endfunction

  // -------------------------------------------------------------
  // pin synchronisers and pulse qualification
  // -------------------------------------------------------------
  // three-stage sync, level changes when stages two and three agree
  always_comb begin
    next_s1 = fast_external_irq_pin_in;
    next_s2 = s1;
    next_s3 = s2;
    next_nmi1 = nmi_n_in;
    next_nmi2 = nmi1;
    next_nmi3 = nmi2;
    next_nmi_lvl = (nmi2 == nmi3) ? nmi2 : nmi_lvl;
    next_lp1 = lp_osc_running_in;
    next_lp2 = lp1;
    next_lp3 = lp2;
    next_irq_lvl = irq_lvl;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (s2[i] == s3[i]) begin
        next_irq_lvl[i] = s2[i];
      end
    end
    irq_act = active_lvl(irq_lvl, irq_active_high_in) & irq_enable_in;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (!irq_act[i]) begin
        next_cnt[i] = 3'h0;
      end else if (cnt[i] < 3'(`PRMC_EXT_IRQ_MIN_CYC)) begin
        next_cnt[i] = cnt[i] + 3'h1;
      end else begin
        next_cnt[i] = cnt[i];
      end
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      irq_wake[i] = (cnt[i] >= 3'(`PRMC_EXT_IRQ_MIN_CYC));
    end
  end

  // sync stages, settled levels and pulse counters
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      irq_lvl <= '0;
      nmi1 <= 1'b1;
      nmi2 <= 1'b1;
      nmi3 <= 1'b1;
      nmi_lvl <= 1'b1;
      lp1 <= 1'b0;
      lp2 <= 1'b0;
      lp3 <= 1'b0;
      for (int i = 0; i < NUM_IRQ; i++) begin
        cnt[i] <= 3'h0;
      end
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      irq_lvl <= next_irq_lvl;
      nmi1 <= next_nmi1;
      nmi2 <= next_nmi2;
      nmi3 <= next_nmi3;
      nmi_lvl <= next_nmi_lvl;
      lp1 <= next_lp1;
      lp2 <= next_lp2;
      lp3 <= next_lp3;
      cnt <= next_cnt;
    end
  end

  // -------------------------------------------------------------
  // mode sequencer
  // -------------------------------------------------------------
  // next mode, pending requests and registered controls
  always_comb begin
    next_state = state;
    next_idle_pend = idle_pend | cpu_in.idle_req;
    next_pd_pend = pd_pend | cpu_in.pd_req;
    next_refused = 1'b0;
    next_wake = 1'b0;
    // ready handshake must have been seen when ready_en is set
    rdy_ok = !cpu_in.ready_en || cpu_in.ready_seen;
    // latch low-power osc as reference once detected
    next_lp_ref = lp_osc_disable_in ? 1'b0 : (lp_ref | (lp2 & lp3));
    case (state)
      prmc_pkg::PRMC_RUN: begin
        // hold entry until bus cycles finish
        if ((next_idle_pend || next_pd_pend) && !cpu_in.bus_busy) begin
          next_idle_pend = 1'b0;
          next_pd_pend = 1'b0;
          if (!rdy_ok) begin
            next_refused = 1'b1;
          end else if (pd_pend || cpu_in.pd_req) begin
            if (!system_config_register_in[`PRMC_VARIANT_BIT]) begin
              if (!nmi_lvl) begin
                next_state = prmc_pkg::PRMC_PD_PROT;
              end else begin
                next_refused = 1'b1;
              end
            end else if (irq_act == '0) begin
              next_state = prmc_pkg::PRMC_PD_INTR;
            end else begin
              next_refused = 1'b1;
            end
          end else begin
            next_state = prmc_pkg::PRMC_IDLE;
          end
        end
      end
      prmc_pkg::PRMC_IDLE: begin
        if (wake_in.any_irq || (irq_wake != '0)) begin
          next_state = prmc_pkg::PRMC_RUN;
          next_wake = 1'b1;
        end
      end
      prmc_pkg::PRMC_PD_INTR: begin
        if ((irq_wake != '0) || wake_in.rtc_irq || wake_in.can_act || wake_in.i2c_act) begin
          next_state = prmc_pkg::PRMC_RUN;
          next_wake = 1'b1;
        end
      end
      prmc_pkg::PRMC_PD_PROT: next_state = prmc_pkg::PRMC_PD_PROT;
      default: next_state = prmc_pkg::PRMC_RUN;
    endcase
    // halt cpu in any low-power mode
    next_halt = (next_state != prmc_pkg::PRMC_RUN);
    // stop peripherals and watchdog in power-down
    next_pclk = !(next_state == prmc_pkg::PRMC_PD_PROT ||
                  next_state == prmc_pkg::PRMC_PD_INTR);
    next_wdt = !next_pclk;
    // main osc stops only with low-power reference
    // main osc kept when it is the reference
    next_mosc = next_pclk || !next_lp_ref;
    next_ref = next_lp_ref;
  end

  // wake pulse restarts clock for interrupt service
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= prmc_pkg::PRMC_RUN;
      idle_pend <= 1'b0;
      pd_pend <= 1'b0;
      lp_ref <= 1'b0;
      cpu_halt_out <= 1'b0;
      periph_clk_en_out <= 1'b1;
      wdt_hold_out <= 1'b0;
      main_osc_en_out <= 1'b1;
      rtc_ref_lp_out <= 1'b0;
      entry_refused_out <= 1'b0;
      wake_irq_out <= 1'b0;
      mode_out <= 4'h1;
    end else begin
      state <= next_state;
      idle_pend <= next_idle_pend;
      pd_pend <= next_pd_pend;
      lp_ref <= next_lp_ref;
      cpu_halt_out <= next_halt;
      periph_clk_en_out <= next_pclk;
      wdt_hold_out <= next_wdt;
      main_osc_en_out <= next_mosc;
      rtc_ref_lp_out <= next_ref;
      entry_refused_out <= next_refused;
      wake_irq_out <= next_wake;
      mode_out <= next_state;
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  // idle keeps peripherals and main osc alive
  a_idle_periph_on: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_IDLE |-> cpu_halt_out && periph_clk_en_out)
    else $error("idle must keep peripherals clocked");
  a_idle_osc_on: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_IDLE |-> !wdt_hold_out && main_osc_en_out)
    else $error("idle stopped watchdog or main osc");
  a_idle_wake_exit: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_IDLE && wake_in.any_irq |=>
      state == prmc_pkg::PRMC_RUN && wake_irq_out)
    else $error("interrupt did not end idle");
  a_idle_pin_wake: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_IDLE && irq_wake != '0 |=>
      state == prmc_pkg::PRMC_RUN && wake_irq_out)
    else $error("fast irq did not end idle");
  // entry conditions
  a_bus_busy_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_RUN && cpu_in.bus_busy |=> state == prmc_pkg::PRMC_RUN)
    else $error("entered low power with bus busy");
  a_ready_refuse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_RUN && cpu_in.ready_en && !cpu_in.ready_seen |=>
      state == prmc_pkg::PRMC_RUN)
    else $error("entered low power without ready");
  a_refuse_in_run: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    entry_refused_out |-> state == prmc_pkg::PRMC_RUN)
    else $error("refused entry left run mode");
  // clocks and oscillators per mode
  a_run_clocks: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_RUN |-> !cpu_halt_out && periph_clk_en_out && !wdt_hold_out &&
      main_osc_en_out)
    else $error("run mode with clocks stopped");
  a_pd_wdt_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == prmc_pkg::PRMC_PD_PROT || state == prmc_pkg::PRMC_PD_INTR) |->
      wdt_hold_out && !periph_clk_en_out)
    else $error("power-down did not hold watchdog");
  a_osc_select: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !periph_clk_en_out |-> main_osc_en_out == !rtc_ref_lp_out)
    else $error("wrong oscillator state in power-down");
  a_lp_adopt: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    lp2 && lp3 && !lp_osc_disable_in |=> rtc_ref_lp_out)
    else $error("low-power osc not adopted");
  a_lp_disable: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    lp_osc_disable_in |=> !rtc_ref_lp_out)
    else $error("low-power osc kept after disable");
  a_pd_main_osc: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !periph_clk_en_out && !rtc_ref_lp_out |-> main_osc_en_out)
    else $error("main osc stopped while it is the reference");
  // power-down variants
  a_variant_prot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(state == prmc_pkg::PRMC_PD_PROT) |-> !$past(system_config_register_in[5]))
    else $error("protected entry with variant bit set");
  a_variant_intr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(state == prmc_pkg::PRMC_PD_INTR) |-> $past(system_config_register_in[5]))
    else $error("interruptible entry with variant bit clear");
  a_prot_nmi: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(state == prmc_pkg::PRMC_PD_PROT) |-> $past(nmi_lvl) == 1'b0)
    else $error("protected entry with nmi high");
  a_prot_stays: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_PD_PROT |=> state == prmc_pkg::PRMC_PD_PROT)
    else $error("protected power-down left without reset");
  a_intr_irq_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(state == prmc_pkg::PRMC_PD_INTR) |-> $past(irq_act) == '0)
    else $error("interruptible entry with fast irq active");
  // wake from interruptible power-down
  a_intr_rtc_wake: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_PD_INTR && wake_in.rtc_irq |=>
      state == prmc_pkg::PRMC_RUN ##0 mode_out == 4'h1)
    else $error("rtc did not end power-down");
  a_intr_bus_wake: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_PD_INTR && (wake_in.can_act || wake_in.i2c_act) |=>
      state == prmc_pkg::PRMC_RUN && wake_irq_out)
    else $error("bus activity did not end power-down");
  a_intr_pin_wake: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    state == prmc_pkg::PRMC_PD_INTR && irq_wake != '0 |=>
      state == prmc_pkg::PRMC_RUN && wake_irq_out && !cpu_halt_out && periph_clk_en_out)
    else $error("fast irq did not restart the clock");
endmodule // prmc_ctrl

/* File: src/prmc_consts.svh */
// Purpose: constants for the power reduction mode control block
// Assumes: 125 MHz system clock
// Notes: timing counts derived from times in ns
`ifndef PRMC_CONSTS_SVH
`define PRMC_CONSTS_SVH
`define PRMC_CLK_PERIOD_NS 8
`define PRMC_VARIANT_BIT 5
`define PRMC_EXT_IRQ_MIN_NS 40
`define PRMC_EXT_IRQ_MIN_CYC ((`PRMC_EXT_IRQ_MIN_NS + `PRMC_CLK_PERIOD_NS - 1) / `PRMC_CLK_PERIOD_NS)
`define PRMC_NUM_EXT_IRQ 8
`endif

/* File: src/prmc_pkg.sv */
// Purpose: types for the power reduction mode control block
// Assumes: nothing
// Notes: one-hot mode states
package prmc_pkg;
  typedef enum logic [3:0] {
    PRMC_RUN = 4'h1,
    PRMC_IDLE = 4'h2,
    PRMC_PD_PROT = 4'h4,
    PRMC_PD_INTR = 4'h8
  } prmc_state_t;
  typedef struct packed {
    logic idle_req;
    logic pd_req;
    logic bus_busy;
    logic ready_en;
    logic ready_seen;
  } prmc_cpu_req_t;
  typedef struct packed {
    logic rtc_irq;
    logic can_act;
    logic i2c_act;
    logic any_irq;
  } prmc_wake_t;
endpackage

/* File: sim/prmc_pin_agent.sv */
// Purpose: far side model, software duty bit and fast interrupt pins
// Assumes: pins are active high as programmed by the bench
// Notes: pulse lasts while fire is held and five cycles after
`timescale 1ns/10ps
module prmc_pin_agent (
  // clock and trigger
  input wire logic sys_clk_in,
  input wire logic fire_in,
  input wire logic [2:0] line_in,
  // pins
  output logic [7:0] fast_external_irq_pin_out,
  output logic main_regulator_off_bit_out
);
  int cnt = 0;
  logic f;
  assign main_regulator_off_bit_out = 1'b1;
  // pin held five cycles, 40 ns
  always @(posedge sys_clk_in) begin
    f = fire_in;
    #1;
    if (f) cnt = 5;
    else if (cnt != 0) cnt = cnt - 1;
  end
  // selected line only, others idle low
  assign fast_external_irq_pin_out = (cnt != 0) ? (8'h01 << line_in) : 8'h00;
endmodule // prmc_pin_agent

/* File: sim/prmc_ctrl_tb_top.sv */
// Purpose: self-checking bench for the mode controller
// Assumes: inputs change 1 ns after the rising edge
// Notes: pulses are caught on the falling edge
`timescale 1ns/10ps
module prmc_ctrl_tb_top;
  logic clk = 0, rst = 1, lp_dis = 0, nmi_n = 1, lp_run = 0, fire = 0, reg_off;
  logic halt, periph, wdt, mosc, ref_lp, refused, wirq;
  int ref_cnt = 0, wake_cnt = 0, ref_base = 0, wake_base = 0;
  logic [15:0] cfg = 16'h0000;
  logic [7:0] pins;
  logic [3:0] mode;
  prmc_pkg::prmc_cpu_req_t cpu = '0;
  prmc_pkg::prmc_wake_t wake = '0;
  int mismatches = 0, checked = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  // pulse counters, sampled mid-cycle
  always @(negedge clk) begin
    if (refused === 1'b1) ref_cnt++;
    if (wirq === 1'b1) wake_cnt++;
  end
  prmc_pin_agent prmc_pin_agent_i (.sys_clk_in(clk), .fire_in(fire), .line_in(3'h0),
    .fast_external_irq_pin_out(pins), .main_regulator_off_bit_out(reg_off));
  prmc_ctrl prmc_ctrl_i (.sys_clk_in(clk), .rst_in(rst), .cpu_in(cpu),
    .system_config_register_in(cfg), .main_regulator_off_bit_in(reg_off),
    .lp_osc_disable_in(lp_dis), .nmi_n_in(nmi_n), .fast_external_irq_pin_in(pins),
    .irq_enable_in(8'h01), .irq_active_high_in(8'h01), .lp_osc_running_in(lp_run),
    .wake_in(wake), .cpu_halt_out(halt), .periph_clk_en_out(periph), .wdt_hold_out(wdt),
    .main_osc_en_out(mosc), .rtc_ref_lp_out(ref_lp), .entry_refused_out(refused),
    .wake_irq_out(wirq), .mode_out(mode));
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle request pulse, pd or idle
  task automatic req(input logic pd);
    ref_base = ref_cnt;
    wake_base = wake_cnt;
    tick();
    cpu.pd_req = pd;
    cpu.idle_req = ~pd;
    tick();
    cpu.pd_req = 0;
    cpu.idle_req = 0;
  endtask
  task automatic wait_mode(input logic [3:0] exp);
    int n;
    n = 0;
    while (mode !== exp && n < 40) begin
      tick();
      n++;
    end
    check({4'h0, mode}, {4'h0, exp});
  endtask
  task automatic final_report();
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #50000;
    mismatches++;
    final_report();
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    // reset held eight cycles at start
    tick(8);
    rst = 0;
    check({halt, periph, wdt, mosc, ref_lp, mode[2:0]}, 8'h51);
    cpu.bus_busy = 1;
    req(0);
    tick(4);
    check({4'h0, mode}, 8'h01);
    cpu.bus_busy = 0;
    wait_mode(4'h2);
    check({6'h00, halt, periph}, 8'h03);
    wake.any_irq = 1;
    wait_mode(4'h1);
    check({6'h00, wirq, halt}, 8'h02);
    wake.any_irq = 0;
    // idle ended by a qualified fast irq pulse
    req(0);
    wait_mode(4'h2);
    fire = 1;
    tick();
    fire = 0;
    wait_mode(4'h1);
    check({6'h00, wirq, halt}, 8'h02);
    cpu.ready_en = 1;
    req(0);
    tick(4);
    check({4'(ref_cnt - ref_base), mode}, 8'h11);
    cpu.ready_en = 0;
    req(1);
    tick(6);
    check({4'(ref_cnt - ref_base), mode}, 8'h11);
    nmi_n = 0;
    tick(4);
    req(1);
    wait_mode(4'h4);
    check({5'h00, halt, periph, wdt}, 8'h05);
    wake = 4'hF;
    fire = 1;
    tick(20);
    check({4'h0, mode}, 8'h04);
    wake = 0;
    fire = 0;
    nmi_n = 1;
    // reset held several cycles to leave power-down
    rst = 1;
    tick(4);
    rst = 0;
    check({4'h0, mode}, 8'h01);
    lp_run = 1;
    cfg = 16'h0020;
    tick(8);
    check({7'h00, ref_lp}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      req(1);
      wait_mode(4'h8);
      check({7'h00, mosc}, 8'h00);
      if (i < 3) wake = 4'h8 >> i;
      else fire = 1;
      tick();
      fire = 0;
      wait_mode(4'h1);
      check({6'h00, wirq, halt}, 8'h02);
      wake = 0;
      tick(10);
    end
    fire = 1;
    tick(5);
    req(1);
    tick(4);
    check({4'(ref_cnt - ref_base), mode}, 8'h11);
    fire = 0;
    lp_dis = 1;
    tick(10);
    check({7'h00, ref_lp}, 8'h00);
    req(1);
    wait_mode(4'h8);
    check({7'h00, mosc}, 8'h01);
    final_report();
  end
endmodule // prmc_ctrl_tb_top
